// >>> psmp_top.sv
/*
 * psmp_top: APB register slave on mclk plus the link-side sequencer that
 * runs single synchronous reads and writes to burst SRAM or a glued FIFO.
 * Assumes both external output clocks are free running and that software
 * changes the configuration only while the port is idle.
 */
// Overview of operation
// RQ1: read latency selectable as zero to three clock cycles.
// RQ2: write latency selectable as zero to three clock cycles.
// RQ3: extend off: chip enable released after the last command is issued.
// RQ4: extend on: chip enable held low whenever output enable is low.
// RQ5: mode zero: strobe is address strobe, deselect cycle follows each access.
// RQ6: mode one: strobe is FIFO read enable, no deselect cycles.
// RQ7: clock select picks first or second output clock for all pin timing.
// RQ8: three shared strobe pins carry strobe, output enable, write enable.
// RQ9: all outputs launched from the rising edge of the selected clock.
// RQ10: read data captured on a rising edge of the selected clock.
// RQ11: latency counted in link cycles from command edge to data edge.
`timescale 1ns/1ps
module psmp_top
(
   input  wire logic                         mclk,
   input  wire logic                         sys_rst,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [psmp_pkg::APB_AW-1:0]  paddr,
   input  wire logic [psmp_pkg::DATA_W-1:0]  pwdata,
   output logic      [psmp_pkg::DATA_W-1:0]  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         ext_clock_out_first,
   input  wire logic                         ext_clock_out_second,
   output logic                              chip_enable_n,
   output logic                              shared_read_strobe_pin,
   output logic                              shared_output_enable_pin,
   output logic                              shared_write_strobe_pin,
   output logic      [psmp_pkg::BE_W-1:0]    byte_enable_n,
   output logic      [psmp_pkg::ADDR_W-1:0]  ext_address_bus,
   output logic      [psmp_pkg::DATA_W-1:0]  ext_data_out,
   output logic                              ext_data_oe,
   input  wire logic [psmp_pkg::DATA_W-1:0]  ext_data_in
);
   logic [psmp_pkg::CFG_W-1:0]   cfg_r;
   logic [psmp_pkg::ADDR_W-1:0]  addr_r;
   logic [psmp_pkg::DATA_W-1:0]  wdata_r;
   logic [psmp_pkg::BE_W-1:0]    be_r;
   logic                         wr_r;
   logic                         busy_r;
   logic                         done_r;
   logic [psmp_pkg::DATA_W-1:0]  rdata_r;
   logic                         req_tgl_r;
   logic                         ack_meta_r;
   logic                         ack_sync_r;
   logic                         ack_prev_r;
   logic                         wr_en;
   logic                         ack_evt;
   logic                         link_clk;
   logic                         lrst_meta_r;
   logic                         lrst_r;
   logic                         req_meta_r;
   logic                         req_sync_r;
   logic                         req_prev_r;
   logic                         ack_tgl_r;
   psmp_pkg::psmp_state_type     state_r;
   logic [1:0]                   cnt_r;
   logic [1:0]                   rl_l_r;
   logic [1:0]                   wl_l_r;
   logic                         ce_ext_l_r;
   logic                         rd_mode_l_r;
   logic                         wr_l_r;
   logic [psmp_pkg::DATA_W-1:0]  rdata_l_r;
   logic                         go;
   logic                         fin;
   logic [1:0]                   lat;
   logic [1:0]                   cnt_inc;

   // apb: zero wait states, errors on unmapped offsets
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign ack_evt = ack_sync_r ^ ack_prev_r;

   always_comb
   begin
      prdata  = '0;
      pslverr = 1'b0;
      if (paddr == psmp_pkg::OFS_CONFIG)
         prdata[psmp_pkg::CFG_W-1:0] = cfg_r;
      else if (paddr == psmp_pkg::OFS_ADDR)
         prdata[psmp_pkg::ADDR_W-1:0] = addr_r;
      else if (paddr == psmp_pkg::OFS_WDATA)
         prdata = wdata_r;
      else if (paddr == psmp_pkg::OFS_CMD)
      begin
         prdata[psmp_pkg::CMD_WRITE] = wr_r;
         prdata[psmp_pkg::CMD_BE_LSB +: psmp_pkg::BE_W] = be_r;
      end
      else if (paddr == psmp_pkg::OFS_STATUS)
      begin
         prdata[psmp_pkg::STS_BUSY] = busy_r;
         prdata[psmp_pkg::STS_DONE] = done_r;
      end
      else if (paddr == psmp_pkg::OFS_RDATA)
         prdata = rdata_r;
      else
         pslverr = psel && penable;
   end

   // setup registers frozen while busy so the link side sees stable values
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cfg_r   <= psmp_pkg::CFG_RST;
         addr_r  <= '0;
         wdata_r <= '0;
      end
      else if (wr_en && !busy_r)
      begin
         if (paddr == psmp_pkg::OFS_CONFIG)
            cfg_r <= pwdata[psmp_pkg::CFG_W-1:0];   // see RQ1 see RQ2 see RQ7
         else if (paddr == psmp_pkg::OFS_ADDR)
            addr_r <= pwdata[psmp_pkg::ADDR_W-1:0];
         else if (paddr == psmp_pkg::OFS_WDATA)
            wdata_r <= pwdata;
      end
   end

   // command start: a start while busy is dropped
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         wr_r      <= 1'b0;
         be_r      <= '0;
         busy_r    <= 1'b0;
         req_tgl_r <= 1'b0;
      end
      else if (wr_en && !busy_r && paddr == psmp_pkg::OFS_CMD && pwdata[psmp_pkg::CMD_START])
      begin
         wr_r      <= pwdata[psmp_pkg::CMD_WRITE];
         be_r      <= pwdata[psmp_pkg::CMD_BE_LSB +: psmp_pkg::BE_W];
         busy_r    <= 1'b1;
         req_tgl_r <= ~req_tgl_r;
      end
      else if (ack_evt)
         busy_r <= 1'b0;
   end

   // completion flag: a new completion wins over a write-one clear
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         done_r <= 1'b0;
      else if (ack_evt)
         done_r <= 1'b1;
      else if (wr_en && paddr == psmp_pkg::OFS_STATUS && pwdata[psmp_pkg::STS_DONE])
         done_r <= 1'b0;
   end

   // ack toggle back from the link; link data is held stable once toggled
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         ack_meta_r <= 1'b0;
         ack_sync_r <= 1'b0;
         ack_prev_r <= 1'b0;
         rdata_r    <= '0;
      end
      else
      begin
         ack_meta_r <= ack_tgl_r;
         ack_sync_r <= ack_meta_r;
         ack_prev_r <= ack_sync_r;
         if (ack_evt && !wr_r)
            rdata_r <= rdata_l_r;
      end
   end

   // clock pick; only safe to change while idle, no glitch filter here
   assign link_clk = cfg_r[psmp_pkg::CFG_SCLK] ? ext_clock_out_second
                                               : ext_clock_out_first;   // see RQ7

   // reset and request toggle brought into the link domain
   always_ff @(posedge link_clk)
   begin
      lrst_meta_r <= sys_rst;
      lrst_r      <= lrst_meta_r;
      if (lrst_r)
      begin
         req_meta_r <= 1'b0;
         req_sync_r <= 1'b0;
         req_prev_r <= 1'b0;
      end
      else
      begin
         req_meta_r <= req_tgl_r;
         req_sync_r <= req_meta_r;
         req_prev_r <= req_sync_r;
      end
   end

   assign go      = (state_r == psmp_pkg::PSMP_IDLE) && (req_sync_r ^ req_prev_r);
   assign lat     = wr_l_r ? wl_l_r : rl_l_r;   // see RQ11
   assign fin     = (state_r == psmp_pkg::PSMP_RUN) && (cnt_r == lat);
   assign cnt_inc = cnt_r + psmp_pkg::LAT_ONE;

   // sequencer: cnt 0 is the command edge, cnt == latency the data edge
   always_ff @(posedge link_clk)
   begin
      if (lrst_r)
      begin
         state_r   <= psmp_pkg::PSMP_IDLE;
         cnt_r     <= psmp_pkg::LAT_ZERO;
         ack_tgl_r <= 1'b0;
         rl_l_r    <= psmp_pkg::LAT_ZERO;
         wl_l_r    <= psmp_pkg::LAT_ZERO;
         ce_ext_l_r  <= 1'b0;
         rd_mode_l_r <= 1'b0;
         wr_l_r    <= 1'b0;
      end
      else
      begin
         case (state_r)
            psmp_pkg::PSMP_IDLE:
            begin
               cnt_r <= psmp_pkg::LAT_ZERO;
               if (go)
               begin
                  state_r   <= psmp_pkg::PSMP_RUN;
                  rl_l_r    <= cfg_r[psmp_pkg::CFG_RL_LSB +: 2];   // see RQ1
                  wl_l_r    <= cfg_r[psmp_pkg::CFG_WL_LSB +: 2];   // see RQ2
                  ce_ext_l_r  <= cfg_r[psmp_pkg::CFG_CE_EXT];
                  rd_mode_l_r <= cfg_r[psmp_pkg::CFG_RD_MODE];
                  wr_l_r    <= wr_r;
               end
            end
            psmp_pkg::PSMP_RUN:
            begin
               cnt_r <= cnt_inc;
               if (fin && rd_mode_l_r)
               begin
                  state_r   <= psmp_pkg::PSMP_IDLE;   // see RQ6
                  ack_tgl_r <= ~ack_tgl_r;
               end
               else if (fin)
                  state_r <= psmp_pkg::PSMP_DESEL;    // see RQ5
            end
            psmp_pkg::PSMP_DESEL:
            begin
               state_r   <= psmp_pkg::PSMP_IDLE;
               ack_tgl_r <= ~ack_tgl_r;
            end
            default:
               state_r <= psmp_pkg::PSMP_IDLE;
         endcase
      end
   end

   // pins, all registered on the selected clock rising edge (see RQ8 see RQ9)
   always_ff @(posedge link_clk)
   begin
      if (lrst_r)
      begin
         chip_enable_n            <= 1'b1;
         shared_read_strobe_pin   <= 1'b1;
         shared_output_enable_pin <= 1'b1;
         shared_write_strobe_pin  <= 1'b1;
         byte_enable_n            <= psmp_pkg::BE_N_IDLE;
         ext_address_bus          <= '0;
         ext_data_out             <= '0;
         ext_data_oe              <= 1'b0;
      end
      else if (go)
      begin
         chip_enable_n            <= 1'b0;
         shared_read_strobe_pin   <= cfg_r[psmp_pkg::CFG_RD_MODE] && wr_r;   // see RQ5 see RQ6
         shared_output_enable_pin <= wr_r;
         shared_write_strobe_pin  <= !wr_r;
         byte_enable_n            <= ~be_r;
         ext_address_bus          <= addr_r;
         ext_data_out             <= wdata_r;
         ext_data_oe              <= wr_r && (cfg_r[psmp_pkg::CFG_WL_LSB +: 2] == psmp_pkg::LAT_ZERO);
      end
      else if (state_r == psmp_pkg::PSMP_RUN)
      begin
         // extend mode keeps select up with output enable for glued FIFOs
         chip_enable_n            <= !(ce_ext_l_r && !wr_l_r && !fin);   // see RQ3 see RQ4
         shared_read_strobe_pin   <= !(fin && !rd_mode_l_r);   // deselect: strobe low, ce high
         shared_write_strobe_pin  <= 1'b1;
         ext_data_oe              <= wr_l_r && !fin && (cnt_inc == wl_l_r);   // see RQ2
         if (fin)
         begin
            shared_output_enable_pin <= 1'b1;
            byte_enable_n            <= psmp_pkg::BE_N_IDLE;
         end
      end
      else
      begin
         chip_enable_n          <= 1'b1;
         shared_read_strobe_pin <= 1'b1;
      end
   end

   // read capture on the data edge of the selected clock
   always_ff @(posedge link_clk)
   begin
      if (lrst_r)
         rdata_l_r <= '0;
      else if (fin && !wr_l_r)
         rdata_l_r <= ext_data_in;   // see RQ10
   end

   AST_RD_LAT0: assert property (@(posedge link_clk) disable iff (lrst_r) // see RQ1
      (state_r == psmp_pkg::PSMP_RUN && cnt_r == 2'h0 && !wr_l_r && rl_l_r == 2'h0) |-> fin)
      else $error("zero latency read not captured at command edge");
   AST_RD_LAT3: assert property (@(posedge link_clk) disable iff (lrst_r) // see RQ11
      (state_r == psmp_pkg::PSMP_RUN && cnt_r == 2'h0 && !wr_l_r && rl_l_r == psmp_pkg::LAT_MAX)
      |-> !fin ##1 !fin ##1 !fin ##1 fin)
      else $error("three cycle read latency wrong");
   AST_WR_LAT1: assert property (@(posedge link_clk) disable iff (lrst_r) // see RQ2
      (state_r == psmp_pkg::PSMP_RUN && cnt_r == 2'h0 && wr_l_r && wl_l_r == 2'h1)
      |-> !ext_data_oe ##1 (ext_data_oe && fin) ##1 !ext_data_oe)
      else $error("write data not at latency one edge");
   AST_CE_STD: assert property (@(posedge link_clk) disable iff (lrst_r) // see RQ3
      (state_r == psmp_pkg::PSMP_RUN && cnt_r == 2'h0 && !ce_ext_l_r) |=> chip_enable_n)
      else $error("chip enable not released after command");
   AST_CE_EXT: assert property (@(posedge link_clk) disable iff (lrst_r) // see RQ4
      (ce_ext_l_r && !shared_output_enable_pin) |-> !chip_enable_n)
      else $error("chip enable dropped while output enable active");
   AST_DESEL: assert property (@(posedge link_clk) disable iff (lrst_r) // see RQ5
      (fin && !rd_mode_l_r) |=> (chip_enable_n && !shared_read_strobe_pin) ##1 shared_read_strobe_pin)
      else $error("deselect cycle missing");
   AST_NODESEL: assert property (@(posedge link_clk) disable iff (lrst_r) // see RQ6
      rd_mode_l_r && state_r != psmp_pkg::PSMP_IDLE |-> !(chip_enable_n && !shared_read_strobe_pin))
      else $error("deselect inserted in fifo mode");
   AST_SCLK_HELD: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ7
      busy_r |=> $stable(cfg_r))
      else $error("clock select changed during access");
   AST_CAPTURE: assert property (@(posedge link_clk) disable iff (lrst_r) // see RQ10
      (fin && !wr_l_r) |=> (rdata_l_r == $past(ext_data_in)))
      else $error("read data not captured on data edge");

   COV_READ: cover property (@(posedge link_clk) disable iff (lrst_r)
      fin && !wr_l_r && rl_l_r == 2'h2);
   COV_WRITE: cover property (@(posedge link_clk) disable iff (lrst_r)
      fin && wr_l_r && wl_l_r == 2'h0);
   COV_FIFO: cover property (@(posedge link_clk) disable iff (lrst_r)
      fin && !wr_l_r && rd_mode_l_r && ce_ext_l_r);
endmodule

// >>> psmp_pkg.sv
/*
 * psmp_pkg: shared constants for the programmable synchronous memory port.
 * Assumes a 32-bit APB master on mclk and a memory clocked by the selected
 * external output clock.
 */
package psmp_pkg;
   // bus and pin widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 20;
   localparam int BE_W   = 4;
   localparam int APB_AW = 8;

   // register byte offsets
   localparam logic [APB_AW-1:0] OFS_CONFIG = 8'h00;
   localparam logic [APB_AW-1:0] OFS_ADDR   = 8'h04;
   localparam logic [APB_AW-1:0] OFS_WDATA  = 8'h08;
   localparam logic [APB_AW-1:0] OFS_CMD    = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h10;
   localparam logic [APB_AW-1:0] OFS_RDATA  = 8'h14;

   // config field positions
   localparam int CFG_RL_LSB = 0;
   localparam int CFG_WL_LSB = 2;
   localparam int CFG_CE_EXT  = 4;
   localparam int CFG_RD_MODE = 5;
   localparam int CFG_SCLK   = 6;
   localparam int CFG_W      = 7;

   // command and status field positions
   localparam int CMD_START  = 0;
   localparam int CMD_WRITE  = 1;
   localparam int CMD_BE_LSB = 4;
   localparam int STS_BUSY   = 0;
   localparam int STS_DONE   = 1;

   // reset values and latency constants
   localparam logic [CFG_W-1:0]  CFG_RST   = 7'h00;
   localparam logic [BE_W-1:0]   BE_N_IDLE = 4'hF;
   localparam logic [1:0]        LAT_ZERO  = 2'h0;
   localparam logic [1:0]        LAT_ONE   = 2'h1;
   localparam logic [1:0]        LAT_MAX   = 2'h3;

   // link sequencer states, gray along idle-run-deselect, two bits change from deselect to idle
   typedef enum logic [1:0] {
      PSMP_IDLE  = 2'b00,
      PSMP_RUN   = 2'b01,
      PSMP_DESEL = 2'b11
   } psmp_state_type;
endpackage

// >>> psmp_mem_model.sv
/*
 * psmp_mem_model: behavioural synchronous SRAM seen by the memory port.
 * Assumes lclk is the selected output clock and rl/wl mirror the config.
 */
`timescale 1ns/1ps
module psmp_mem_model
(
   input  wire logic        lclk,
   input  wire logic [1:0]  rl,
   input  wire logic [1:0]  wl,
   input  wire logic        ce_n,
   input  wire logic        strobe_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [3:0]  be_n,
   input  wire logic [19:0] addr,
   input  wire logic [31:0] dout,
   input  wire logic        doe,
   output logic      [31:0] din
);
   logic [31:0] mem [16];
   logic [31:0] last_r = 32'h0;
   logic [31:0] wbus;
   logic [2:0]  rage_r = 3'h0;
   logic [2:0]  wage_r = 3'h0;
   logic [3:0]  ra_r;
   logic [3:0]  wa_r;
   logic [3:0]  wbe_r;
   logic        rd_now;
   logic        wr_now;
   logic        show;

   // command decode on the shared strobes
   assign rd_now = !ce_n && !strobe_n && !oe_n;
   assign wr_now = !ce_n && !we_n;
   // data only for the capture edge, else a changing pattern
   assign show = (rl == 2'h0) ? rd_now : (rage_r == {1'b0, rl});
   assign din = show ? mem[(rl == 2'h0) ? addr[3:0] : ra_r] : ~last_r;
   // an undriven data bus must not pass for good data
   assign wbus = doe ? dout : ~dout;

   // command ages and write capture at command edge plus latency
   always @(posedge lclk)
   begin
      last_r <= din;
      if (rd_now)
      begin
         rage_r <= 3'h1;
         ra_r   <= addr[3:0];
      end
      else if (rage_r != 3'h0)
         rage_r <= rage_r + 3'h1;
      if (wr_now)
      begin
         wage_r <= 3'h1;
         wa_r   <= addr[3:0];
         wbe_r  <= be_n;
      end
      else if (wage_r != 3'h0)
         wage_r <= wage_r + 3'h1;
      for (int b = 0; b < 4; b++)
      begin
         if (wr_now && wl == 2'h0 && !be_n[b])
            mem[addr[3:0]][8*b +: 8] <= wbus[8*b +: 8];
         if (!wr_now && wl != 2'h0 && wage_r == {1'b0, wl} && !wbe_r[b])
            mem[wa_r][8*b +: 8] <= wbus[8*b +: 8];
      end
   end
endmodule

// >>> tb_top.sv
/*
 * tb_top: self-checking bench for psmp_top with an SRAM model on the link.
 * Assumes free-running 48 ns output clocks and a zero-wait APB slave.
 */
`timescale 1ns/1ps
module tb_top;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        ck1 = 1'b0;
   logic        ck2 = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ce_n;
   logic        rs_n;
   logic        oe_n;
   logic        we_n;
   logic [3:0]  be_n;
   logic [19:0] ea;
   logic [31:0] dout;
   logic        doe;
   logic [31:0] din;
   logic        lclk;
   logic [6:0]  cfg_r = 7'h00;
   logic [31:0] rdat;
   logic        rerr;
   logic [31:0] dv [16];
   realtime     t_sel = 0.0;
   int          n_errors = 0;
   int          n_compared = 0;
   int          n_gap;
   int          n_desel;
   int          cyc = 0;

   // clocks; second output clock offset so a wrong pick shows
   always #2.5 mclk = ~mclk;
   always #24 ck1 = ~ck1;
   initial
   begin
      #17;
      forever #24 ck2 = ~ck2;
   end
   assign lclk = cfg_r[6] ? ck2 : ck1;

   psmp_top uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clock_out_first(ck1), .ext_clock_out_second(ck2),
      .chip_enable_n(ce_n), .shared_read_strobe_pin(rs_n), .shared_output_enable_pin(oe_n),
      .shared_write_strobe_pin(we_n), .byte_enable_n(be_n), .ext_address_bus(ea),
      .ext_data_out(dout), .ext_data_oe(doe), .ext_data_in(din));

   psmp_mem_model mem (.lclk(lclk), .rl(cfg_r[1:0]), .wl(cfg_r[3:2]), .ce_n(ce_n),
      .strobe_n(rs_n), .oe_n(oe_n), .we_n(we_n), .be_n(be_n), .addr(ea), .dout(dout),
      .doe(doe), .din(din));

   // pin activity watchers on the selected clock
   always @(posedge lclk)
   begin
      t_sel = $realtime;
      if (!oe_n && ce_n)
         n_gap++;
      if (ce_n && !rs_n)
         n_desel++;
   end
   always @(ce_n)
      if ($realtime - t_sel > 5.0)
      begin
         n_errors++;
         $display("Error chip_enable_n edge expected near selected clock seen %0t", $realtime);
      end

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // hang guard, well above the expected few thousand cycles
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_errors++;
         conclude();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // one access; poke tries a config write while busy
   task automatic access(input logic [6:0] cfg, input logic wr, input logic [3:0] a,
                         input logic [31:0] d, input logic [3:0] be, input logic poke);
      apb(1'b1, psmp_pkg::OFS_CONFIG, {25'h0, cfg});
      cfg_r = cfg;
      apb(1'b1, psmp_pkg::OFS_ADDR, {28'h0, a});
      apb(1'b1, psmp_pkg::OFS_WDATA, d);
      n_gap = 0;
      n_desel = 0;
      apb(1'b1, psmp_pkg::OFS_CMD, {24'h0, be, 2'b00, wr, 1'b1});
      if (poke)
      begin
         apb(1'b1, psmp_pkg::OFS_CONFIG, {25'h0, ~cfg});
         apb(1'b0, psmp_pkg::OFS_CONFIG, 32'h0);
         chk("config while busy", {25'h0, cfg}, rdat);
      end
      do
         apb(1'b0, psmp_pkg::OFS_STATUS, 32'h0);
      while (rdat[psmp_pkg::STS_BUSY] !== 1'b0 || rdat[psmp_pkg::STS_DONE] !== 1'b1);
      apb(1'b1, psmp_pkg::OFS_STATUS, 32'h2);
      apb(1'b0, psmp_pkg::OFS_STATUS, 32'h0);
      chk("done cleared", 32'h0, rdat);
      apb(1'b0, psmp_pkg::OFS_RDATA, 32'h0);
   endtask

   task automatic t_regs();
      apb(1'b0, psmp_pkg::OFS_CONFIG, 32'h0);
      chk("config reset", 32'h0, rdat);
      chk("mapped error", 32'h0, {31'h0, rerr});
      apb(1'b0, psmp_pkg::OFS_STATUS, 32'h0);
      chk("status reset", 32'h0, rdat);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, rerr});
   endtask

   // every latency pair, with extend, strobe mode and clock varied
   task automatic t_lat();
      logic [6:0] c;
      for (int i = 0; i < 16; i++)
      begin
         c = {i[2], i[1] ^ i[2], i[0] ^ i[3], i[3:2], i[1:0]};
         dv[i] = 32'h5A0000C3 ^ (i * 32'h01030507);
         access(c, 1'b1, i[3:0], dv[i], 4'hF, 1'b0);
         access(c, 1'b0, i[3:0], 32'h0, 4'hF, i == 5);
         chk("read data", dv[i], rdat);
         if (c[4])
            chk("ce gap", 32'h0, n_gap);
         else if (c[1:0] != 2'h0)
            chk("ce released", 32'h1, {31'h0, n_gap > 0});
         chk("deselect", {31'h0, !c[5]}, {31'h0, n_desel > 0});
      end
   endtask

   task automatic t_bytes();
      access(7'h05, 1'b1, 4'h2, 32'hFFFFFFFF, 4'h5, 1'b0);
      access(7'h05, 1'b0, 4'h2, 32'h0, 4'hF, 1'b0);
      chk("byte lanes", (dv[2] & 32'hFF00FF00) | 32'h00FF00FF, rdat);
   endtask

   initial
   begin
      // long reset so the link side sees four of its own edges
      repeat (40) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (40) @(posedge mclk);
      t_regs();
      t_lat();
      t_bytes();
      conclude();
   end
endmodule
